// ### aivp_consts.vh
// Constants for the analog input value processing block.
// Assumes inclusion by the main design file of the block, by bare name.
`ifndef AIVP_CONSTS_VH
`define AIVP_CONSTS_VH
// ****************************************
// Register indices (register numbers).
// ****************************************
`define AIVP_IDX_RAW 6'h00
`define AIVP_IDX_HW_OFS 6'h11
`define AIVP_IDX_HW_GAIN 6'h12
`define AIVP_IDX_FAC_OFS 6'h13
`define AIVP_IDX_FAC_GAIN 6'h14
`define AIVP_IDX_UPPER 6'h15
`define AIVP_IDX_LOWER 6'h16
`define AIVP_IDX_KEY 6'h1f
`define AIVP_IDX_CFG 6'h20
`define AIVP_IDX_USR_OFS 6'h21
`define AIVP_IDX_USR_GAIN 6'h22
`define AIVP_IDX_THR1 6'h23
`define AIVP_IDX_THR2 6'h24
`define AIVP_IDX_IIR 6'h25
// ****************************************
// Reset values.
// ****************************************
`define AIVP_RST_HW_OFS 16'h0000
`define AIVP_RST_HW_GAIN 16'h1350
`define AIVP_RST_FAC_OFS 16'h0000
`define AIVP_RST_FAC_GAIN 16'h2000
`define AIVP_RST_UPPER 16'h0fff
`define AIVP_RST_LOWER 16'h0000
`define AIVP_RST_KEY 16'h0000
`define AIVP_RST_CFG 16'h0906
`define AIVP_RST_USR_OFS 16'h0000
`define AIVP_RST_USR_GAIN 16'h0400
`define AIVP_RST_THR 16'h0000
`define AIVP_RST_IIR 16'h0100
`define AIVP_UNLOCK_KEY 16'h1235
// ****************************************
// Field positions.
// ****************************************
`define AIVP_CFG_USR_EN 0
`define AIVP_CFG_FAC_BYP 1
`define AIVP_CFG_WD_EN 2
`define AIVP_CFG_SIGNMAG 3
`define AIVP_CFG_ALT_FMT 4
`define AIVP_CFG_RANGE_EN 8
`define AIVP_CFG_THR1_EN 9
`define AIVP_CFG_THR2_EN 10
`define AIVP_CFG_FILT_EN 11
`define AIVP_CTL_REG_MODE 7
`define AIVP_CTL_WRITE 6
`define AIVP_HW_FRAC 12
`define AIVP_FAC_FRAC 10
`define AIVP_USR_FRAC 10
// ****************************************
// Timing.
// ****************************************
`define AIVP_CLK_HZ 40000000
`define AIVP_WD_TIME_MS 100
`define AIVP_WD_CYCLES (`AIVP_WD_TIME_MS * (`AIVP_CLK_HZ / 1000))
`endif

// ### aivp_nv_store.v
// Nonvolatile word store for the user registers of one channel.
// Assumes nv_erase is pulsed once before first use; rstn does not touch it.
`timescale 1ns/1ps
module aivp_nv_store #(
  parameter AW = 6,
  parameter DW = 16
) (
  input wire clk, // Block clock.
  input wire nv_erase, // Wipes every word to unprogrammed.
  input wire wr_en, // Write strobe.
  input wire [AW-1:0] wr_addr, // Write address.
  input wire [DW-1:0] wr_data, // Write data.
  input wire [AW-1:0] rd_addr, // Read address.
  output reg [DW-1:0] rd_data_q, // Registered read data.
  output reg rd_valid_q // Word at rd_addr has been programmed.
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  reg [(1<<AW)-1:0] prog_q;

  // Contents survive a block reset, which is the point of this store.
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_q <= mem[rd_addr];
  end

  // Programmed marks; only an erase clears them.
  always @(posedge clk) begin
    if (nv_erase) begin
      prog_q <= {(1<<AW){1'b0}};
    end else if (wr_en) begin
      prog_q[wr_addr] <= 1'b1;
    end
    rd_valid_q <= prog_q[rd_addr] & ~nv_erase;
  end
endmodule

// ### aivp_scale.v
// Gain and offset stage with saturation to a signed 16-bit result.
// Assumes gain carries FRAC fractional bits; purely combinational.
`timescale 1ns/1ps
module aivp_scale #(
  parameter FRAC = 10,
  parameter OFS_FIRST = 0
) (
  input wire [15:0] x, // Signed input value.
  input wire [15:0] gain, // Signed fixed-point gain.
  input wire [15:0] ofs, // Signed offset.
  output wire [15:0] y // Saturated signed result.
);
  wire signed [16:0] xo;
  wire signed [32:0] prod;
  wire signed [32:0] shf;
  wire signed [33:0] sum;
  wire ovf;

  // Offset goes before or after the multiply depending on the stage.
  assign xo = OFS_FIRST ? ($signed({x[15], x}) + $signed({ofs[15], ofs}))
                        : $signed({x[15], x});
  assign prod = xo * $signed(gain);
  assign shf = prod >>> FRAC;
  assign sum = OFS_FIRST ? $signed({shf[32], shf})
                         : ($signed({shf[32], shf}) +
                            $signed({{18{ofs[15]}}, ofs}));
  // Saturate rather than wrap, so a large gain never flips the sign.
  assign ovf = ~(&sum[33:15] | ~|sum[33:15]);
  assign y = ovf ? (sum[33] ? 16'h8000 : 16'h7fff) : sum[15:0];
endmodule

// ### aivp_main.v
// Value processing and register file of one analog current input channel.
// Assumes raw samples and host process-data cycles arrive on clk.
// Overview of operation
// - Signed hardware offset, default zero, added in the first stage.
// - Signed hardware gain, 12 fraction bits, multiplies the first stage.
// - Signed factory scaling offset, default zero, added after the gain.
// - Signed factory scaling gain with 10 fraction bits, typically 0x2000.
// - Config bit 1 clear applies factory scaling, set bypasses; default set.
// - Above upper limit, set over-range flag and output the upper limit.
// - Below lower limit, set under-range flag and output the lower limit.
// - User register writes ignored unless the key register holds 0x1235.
// - Accepted user writes go to working copy and nonvolatile store.
// - Every restart clears the key register, re-arming write protection.
// - Sixteen-bit configuration register with default 0x0906.
// - Config bit 11 enables the first-order filter; default on.
// - Config bits 9 and 10 enable thresholds one and two; default off.
// - Config bit 8 enables range flags and clamping; default on.
// - Config bit 4 selects the format with status in the three low bits.
// - In that format the value sits in bits 15 to 3, sign in 15.
// - Config bit 3 selects sign-magnitude output, minus one is 0x8001.
// - Config bit 2 trips the watchdog after 100 ms without process data.
// - Config bit 0 enables user scaling, else it is bypassed.
// - Live-zero variant: low gives bits 011, high gives 001, else 000.
// - Zero-based variant: high gives 001, otherwise data with 000.
// - User gain 0x0400 is a factor of exactly one.
// - Control byte: bit 7 register mode, bit 6 write, bits 5..0 index.
`timescale 1ns/1ps
`include "aivp_consts.vh"
module aivp_main #(
  parameter LIVE_ZERO = 1,
  parameter WD_CYCLES = `AIVP_WD_CYCLES
) (
  input wire clk, // Block clock, 40 MHz.
  input wire rstn, // Synchronous reset, active low.
  input wire nv_erase, // Wipes the nonvolatile store.
  input wire [15:0] raw_value, // Signed converter sample.
  input wire raw_valid, // Sample strobe.
  input wire host_valid, // Process data cycle from the host.
  input wire [7:0] ctrl_byte, // Host control byte.
  input wire [15:0] host_data, // Host output data word.
  output reg [7:0] status_byte_q, // Answer status byte.
  output reg [15:0] data_in_q, // Answer data word.
  output reg ans_valid_q, // Answer strobe.
  output reg [15:0] pd_word_q, // Latest formatted process value.
  output reg pd_valid_q, // Process value strobe.
  output reg wd_trip_q, // Host watchdog tripped.
  output reg load_busy_q // Restoring settings after restart.
);
  localparam ST_LOAD = 1'b0;
  localparam ST_RUN = 1'b1;
  localparam [31:0] WD_LAST = WD_CYCLES - 1;

  // ****************************************
  // Decoding helpers.
  // ****************************************
  // Registers that are persisted and protected by the key.
  function is_user;
    input [5:0] idx;
    begin
      is_user = (idx >= `AIVP_IDX_HW_OFS && idx <= `AIVP_IDX_LOWER) ||
                (idx >= `AIVP_IDX_CFG && idx <= `AIVP_IDX_IIR);
    end
  endfunction

  // ****************************************
  // State.
  // ****************************************
  reg [15:0] hw_offset_comp_q;
  reg [15:0] hw_gain_comp_q;
  reg [15:0] factory_scale_offset_q;
  reg [15:0] factory_scale_gain_q;
  reg [15:0] upper_range_limit_q;
  reg [15:0] lower_range_limit_q;
  reg [15:0] write_unlock_key_q;
  reg [15:0] processing_config_q;
  reg [15:0] user_offset_q;
  reg [15:0] user_gain_q;
  reg [15:0] thr1_q;
  reg [15:0] thr2_q;
  reg [15:0] iir_ctl_q;
  reg [15:0] raw_q;
  reg [15:0] filt_q;
  reg over_q;
  reg under_q;
  reg thr1_hit_q;
  reg thr2_hit_q;
  reg state_q;
  reg [5:0] ld_addr_q;
  reg [5:0] ld_prev_q;
  reg ld_prev_v_q;
  reg [31:0] wd_cnt_q;
  wire [15:0] nv_rd_data;
  wire nv_rd_valid;

  // ****************************************
  // Write path.
  // ****************************************
  wire [5:0] req_idx = ctrl_byte[5:0];
  wire reg_mode = host_valid && ctrl_byte[`AIVP_CTL_REG_MODE];
  wire host_wr = reg_mode && ctrl_byte[`AIVP_CTL_WRITE] && state_q == ST_RUN;
  wire unlocked = write_unlock_key_q == `AIVP_UNLOCK_KEY;
  // Protected writes only pass with the key in place.
  wire user_wr = host_wr && unlocked && is_user(req_idx);
  wire key_wr = host_wr && req_idx == `AIVP_IDX_KEY;
  wire ld_wr = state_q == ST_LOAD && ld_prev_v_q && nv_rd_valid &&
               is_user(ld_prev_q);
  wire any_wr = user_wr || ld_wr;
  wire [5:0] wr_idx = ld_wr ? ld_prev_q : req_idx;
  wire [15:0] wr_data = ld_wr ? nv_rd_data : host_data;

  // Accepted user writes are mirrored into the store so they survive.
  aivp_nv_store #(
    .AW(6),
    .DW(16)
  ) u_store (
    .clk(clk),
    .nv_erase(nv_erase),
    .wr_en(user_wr),
    .wr_addr(req_idx),
    .wr_data(host_data),
    .rd_addr(ld_addr_q),
    .rd_data_q(nv_rd_data),
    .rd_valid_q(nv_rd_valid)
  );

  // Working copies; defaults stand until the store restores saved words.
  always @(posedge clk) begin
    if (!rstn) begin
      hw_offset_comp_q <= `AIVP_RST_HW_OFS;
      hw_gain_comp_q <= `AIVP_RST_HW_GAIN;
      factory_scale_offset_q <= `AIVP_RST_FAC_OFS;
      factory_scale_gain_q <= `AIVP_RST_FAC_GAIN;
      upper_range_limit_q <= `AIVP_RST_UPPER;
      lower_range_limit_q <= `AIVP_RST_LOWER;
      processing_config_q <= `AIVP_RST_CFG;
      user_offset_q <= `AIVP_RST_USR_OFS;
      user_gain_q <= `AIVP_RST_USR_GAIN;
      thr1_q <= `AIVP_RST_THR;
      thr2_q <= `AIVP_RST_THR;
      iir_ctl_q <= `AIVP_RST_IIR;
    end else if (any_wr) begin
      if (wr_idx == `AIVP_IDX_HW_OFS) begin
        hw_offset_comp_q <= wr_data;
      end else if (wr_idx == `AIVP_IDX_HW_GAIN) begin
        hw_gain_comp_q <= wr_data;
      end else if (wr_idx == `AIVP_IDX_FAC_OFS) begin
        factory_scale_offset_q <= wr_data;
      end else if (wr_idx == `AIVP_IDX_FAC_GAIN) begin
        factory_scale_gain_q <= wr_data;
      end else if (wr_idx == `AIVP_IDX_UPPER) begin
        upper_range_limit_q <= wr_data;
      end else if (wr_idx == `AIVP_IDX_LOWER) begin
        lower_range_limit_q <= wr_data;
      end else if (wr_idx == `AIVP_IDX_CFG) begin
        processing_config_q <= wr_data;
      end else if (wr_idx == `AIVP_IDX_USR_OFS) begin
        user_offset_q <= wr_data;
      end else if (wr_idx == `AIVP_IDX_USR_GAIN) begin
        user_gain_q <= wr_data;
      end else if (wr_idx == `AIVP_IDX_THR1) begin
        thr1_q <= wr_data;
      end else if (wr_idx == `AIVP_IDX_THR2) begin
        thr2_q <= wr_data;
      end else if (wr_idx == `AIVP_IDX_IIR) begin
        iir_ctl_q <= wr_data;
      end
    end
  end

  // The key lives only in volatile storage, so a restart re-locks.
  always @(posedge clk) begin
    if (!rstn) begin
      write_unlock_key_q <= `AIVP_RST_KEY;
    end else if (key_wr) begin
      write_unlock_key_q <= host_data;
    end
  end

  // ****************************************
  // Restore sequence after restart.
  // ****************************************
  // Walks the persisted indices; the store answers one cycle later.
  always @(posedge clk) begin
    if (!rstn) begin
      state_q <= ST_LOAD;
      ld_addr_q <= `AIVP_IDX_HW_OFS;
      ld_prev_q <= 6'h00;
      ld_prev_v_q <= 1'b0;
      load_busy_q <= 1'b1;
    end else begin
      case (state_q)
        ST_LOAD: begin
          ld_prev_q <= ld_addr_q;
          ld_prev_v_q <= 1'b1;
          ld_addr_q <= ld_addr_q + 6'h01;
          if (ld_prev_v_q && ld_prev_q == `AIVP_IDX_IIR) begin
            state_q <= ST_RUN;
            load_busy_q <= 1'b0;
          end
        end
        default: begin
          ld_prev_v_q <= 1'b0;
          load_busy_q <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Processing chain.
  // ****************************************
  wire [15:0] hw_y;
  wire [15:0] fac_y;
  wire [15:0] usr_y;

  // First stage adds the offset, then multiplies by the gain.
  aivp_scale #(
    .FRAC(`AIVP_HW_FRAC),
    .OFS_FIRST(1)
  ) u_hw (
    .x(raw_value),
    .gain(hw_gain_comp_q),
    .ofs(hw_offset_comp_q),
    .y(hw_y)
  );

  aivp_scale #(
    .FRAC(`AIVP_FAC_FRAC),
    .OFS_FIRST(0)
  ) u_fac (
    .x(hw_y),
    .gain(factory_scale_gain_q),
    .ofs(factory_scale_offset_q),
    .y(fac_y)
  );

  // Factory stage enable is inverted: a set bit means bypass.
  wire fac_byp = processing_config_q[`AIVP_CFG_FAC_BYP];
  wire [15:0] fac_v = fac_byp ? hw_y : fac_y;

  aivp_scale #(
    .FRAC(`AIVP_USR_FRAC),
    .OFS_FIRST(0)
  ) u_usr (
    .x(fac_v),
    .gain(user_gain_q),
    .ofs(user_offset_q),
    .y(usr_y)
  );

  wire usr_en = processing_config_q[`AIVP_CFG_USR_EN];
  wire [15:0] usr_v = usr_en ? usr_y : fac_v;

  // Range protection: both flags and the clamp follow the one enable.
  wire rng_en = processing_config_q[`AIVP_CFG_RANGE_EN];
  wire over_d = rng_en &&
                $signed(usr_v) > $signed(upper_range_limit_q);
  wire under_d = rng_en &&
                 $signed(usr_v) < $signed(lower_range_limit_q);
  wire [15:0] clamp_v = over_d ? upper_range_limit_q :
                        under_d ? lower_range_limit_q :
                        usr_v;

  // First-order filter; an unknown cut-off code leaves it off.
  wire filt_on = processing_config_q[`AIVP_CFG_FILT_EN] &&
                 iir_ctl_q[7:0] == 8'h00 && iir_ctl_q[15:8] >= 8'h01 &&
                 iir_ctl_q[15:8] <= 8'h04;
  wire [2:0] filt_k = iir_ctl_q[10:8] + 3'h1;
  wire signed [16:0] filt_diff = $signed({clamp_v[15], clamp_v}) -
                                 $signed({filt_q[15], filt_q});
  wire signed [16:0] filt_step = filt_diff >>> filt_k;
  wire signed [16:0] filt_sum = $signed({filt_q[15], filt_q}) + filt_step;
  wire [15:0] filt_d = filt_on ? filt_sum[15:0] : clamp_v;

  // Thresholds are checked on the value that is about to be output.
  wire thr1_d = processing_config_q[`AIVP_CFG_THR1_EN] &&
                $signed(filt_d) > $signed(thr1_q);
  wire thr2_d = processing_config_q[`AIVP_CFG_THR2_EN] &&
                $signed(filt_d) > $signed(thr2_q);

  // Sign-magnitude keeps the sign bit and negates the rest.
  wire sm_on = processing_config_q[`AIVP_CFG_SIGNMAG];
  wire [14:0] mag = (~filt_d[14:0]) + 15'h0001;
  wire [15:0] rep_v = (sm_on && filt_d[15]) ? {1'b1, mag} :
                      filt_d;

  // Alternative format packs the value high and status low.
  reg [15:0] fmt_v;
  always @* begin
    fmt_v = rep_v;
    if (processing_config_q[`AIVP_CFG_ALT_FMT]) begin
      fmt_v = {rep_v[15], rep_v[11:0], 3'b000};
      if (over_d) begin
        fmt_v = 16'h0001;
      end else if (under_d && LIVE_ZERO != 0) begin
        fmt_v = 16'h0003;
      end
    end
  end

  // Sample registers; one strobe in, one strobe out a cycle later.
  always @(posedge clk) begin
    if (!rstn) begin
      raw_q <= 16'h0000;
      filt_q <= 16'h0000;
      pd_word_q <= 16'h0000;
      pd_valid_q <= 1'b0;
      over_q <= 1'b0;
      under_q <= 1'b0;
      thr1_hit_q <= 1'b0;
      thr2_hit_q <= 1'b0;
    end else begin
      pd_valid_q <= raw_valid;
      if (raw_valid) begin
        raw_q <= raw_value;
        filt_q <= filt_d;
        pd_word_q <= fmt_v;
        over_q <= over_d;
        under_q <= under_d;
        thr1_hit_q <= thr1_d;
        thr2_hit_q <= thr2_d;
      end
    end
  end

  // ****************************************
  // Host watchdog.
  // ****************************************
  // Any process data cycle restarts the count; disabling clears the trip.
  always @(posedge clk) begin
    if (!rstn) begin
      wd_cnt_q <= 32'h0000_0000;
      wd_trip_q <= 1'b0;
    end else if (host_valid ||
                 !processing_config_q[`AIVP_CFG_WD_EN]) begin
      wd_cnt_q <= 32'h0000_0000;
      wd_trip_q <= 1'b0;
    end else if (wd_cnt_q < WD_LAST) begin
      wd_cnt_q <= wd_cnt_q + 32'h0000_0001;
    end else begin
      wd_trip_q <= 1'b1;
    end
  end

  // ****************************************
  // Host answers.
  // ****************************************
  reg [15:0] rd_v;
  always @* begin
    rd_v = 16'h0000;
    if (req_idx == `AIVP_IDX_RAW) begin
      rd_v = raw_q;
    end else if (req_idx == `AIVP_IDX_HW_OFS) begin
      rd_v = hw_offset_comp_q;
    end else if (req_idx == `AIVP_IDX_HW_GAIN) begin
      rd_v = hw_gain_comp_q;
    end else if (req_idx == `AIVP_IDX_FAC_OFS) begin
      rd_v = factory_scale_offset_q;
    end else if (req_idx == `AIVP_IDX_FAC_GAIN) begin
      rd_v = factory_scale_gain_q;
    end else if (req_idx == `AIVP_IDX_UPPER) begin
      rd_v = upper_range_limit_q;
    end else if (req_idx == `AIVP_IDX_LOWER) begin
      rd_v = lower_range_limit_q;
    end else if (req_idx == `AIVP_IDX_KEY) begin
      rd_v = write_unlock_key_q;
    end else if (req_idx == `AIVP_IDX_CFG) begin
      rd_v = processing_config_q;
    end else if (req_idx == `AIVP_IDX_USR_OFS) begin
      rd_v = user_offset_q;
    end else if (req_idx == `AIVP_IDX_USR_GAIN) begin
      rd_v = user_gain_q;
    end else if (req_idx == `AIVP_IDX_THR1) begin
      rd_v = thr1_q;
    end else if (req_idx == `AIVP_IDX_THR2) begin
      rd_v = thr2_q;
    end else if (req_idx == `AIVP_IDX_IIR) begin
      rd_v = iir_ctl_q;
    end
  end

  // Register mode echoes the control byte, with bit 6 cleared on writes.
  // Requests during the restore are dropped; load_busy_q shows why.
  always @(posedge clk) begin
    if (!rstn) begin
      status_byte_q <= 8'h00;
      data_in_q <= 16'h0000;
      ans_valid_q <= 1'b0;
    end else begin
      ans_valid_q <= host_valid && state_q == ST_RUN;
      if (host_valid && state_q == ST_RUN) begin
        if (reg_mode) begin
          status_byte_q <= {ctrl_byte[7], 1'b0, ctrl_byte[5:0]};
          data_in_q <= ctrl_byte[`AIVP_CTL_WRITE] ? 16'h0000 : rd_v;
        end else begin
          status_byte_q <= {1'b0, over_q | under_q, wd_trip_q, 1'b0,
                            thr2_hit_q, thr1_hit_q, over_q, under_q};
          data_in_q <= pd_word_q;
        end
      end
    end
  end
endmodule

// ### aivp_main_sva.sv
// Checker for the value processing block, watching its ports only.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module aivp_main_chk #(
  parameter WD_CYCLES = 50
) (
  input wire clk, // Block clock.
  input wire rstn, // Reset, active low.
  input wire raw_valid, // Sample strobe.
  input wire host_valid, // Host request strobe.
  input wire [7:0] ctrl_byte, // Host control byte.
  input wire load_busy_q, // Restore in progress.
  input wire ans_valid_q, // Answer strobe.
  input wire [7:0] status_byte_q, // Answer status.
  input wire [15:0] data_in_q, // Answer data.
  input wire pd_valid_q, // Process value strobe.
  input wire [15:0] pd_word_q, // Process value.
  input wire wd_trip_q // Watchdog tripped.
);
  // ****************************************
  // Helper logic and properties.
  // ****************************************
  reg [31:0] idle_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Cycles since the last host cycle; saturates so it never wraps.
  always @(posedge clk) begin
    if (!rstn || host_valid)
      idle_q <= 32'h0;
    else if (idle_q != 32'hffffffff)
      idle_q <= idle_q + 32'h1;
  end
  property p_ans_lat;
    host_valid && !load_busy_q |=> ans_valid_q;
  endproperty
  a_ans_lat: assert property (p_ans_lat)
    else $error("answer missing");
  property p_ans_src;
    ans_valid_q |-> $past(host_valid) && !$past(load_busy_q);
  endproperty
  a_ans_src: assert property (p_ans_src)
    else $error("stray answer");
  property p_rd_echo;
    host_valid && !load_busy_q && ctrl_byte[7] && !ctrl_byte[6]
      |=> status_byte_q == $past(ctrl_byte);
  endproperty
  a_rd_echo: assert property (p_rd_echo) else $error("read echo");
  property p_wr_echo;
    host_valid && !load_busy_q && ctrl_byte[7] && ctrl_byte[6]
      |=> status_byte_q == {1'b1, 1'b0, $past(ctrl_byte[5:0])};
  endproperty
  a_wr_echo: assert property (p_wr_echo) else $error("write echo");
  property p_pd_lat;
    raw_valid |=> pd_valid_q;
  endproperty
  a_pd_lat: assert property (p_pd_lat) else $error("sample late");
  property p_pd_hold;
    !raw_valid |=> !pd_valid_q && $stable(pd_word_q);
  endproperty
  a_pd_hold: assert property (p_pd_hold)
    else $error("value moved");
  property p_data_hold;
    !ans_valid_q |-> $stable(data_in_q);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("data moved");
  property p_wd_clr;
    host_valid |=> !wd_trip_q;
  endproperty
  a_wd_clr: assert property (p_wd_clr) else $error("trip stuck");
  property p_wd_early;
    $rose(wd_trip_q) |-> idle_q >= WD_CYCLES;
  endproperty
  a_wd_early: assert property (p_wd_early)
    else $error("trip early");
  property p_load_end;
    $rose(rstn) |-> ##[1:40] !load_busy_q;
  endproperty
  a_load_end: assert property (p_load_end)
    else $error("restore hung");
  c_trip: cover property ($rose(wd_trip_q));
  c_write: cover property (host_valid && ctrl_byte[6] && !load_busy_q);
  c_sample: cover property (pd_valid_q);
endmodule
bind aivp_main aivp_main_chk #(.WD_CYCLES(WD_CYCLES)) u_chk (
  .clk(clk), .rstn(rstn), .raw_valid(raw_valid), .host_valid(host_valid),
  .ctrl_byte(ctrl_byte), .load_busy_q(load_busy_q),
  .ans_valid_q(ans_valid_q), .status_byte_q(status_byte_q),
  .data_in_q(data_in_q), .pd_valid_q(pd_valid_q), .pd_word_q(pd_word_q),
  .wd_trip_q(wd_trip_q));

// ### aivp_host_model.sv
// Model of the bus coupler issuing register and process cycles.
// Assumes the caller checks the answer one cycle after each cycle.
`timescale 1ns/1ps
module aivp_host_model (
  input wire clk, // Block clock.
  output logic [7:0] ctrl_byte, // Control byte.
  output logic [15:0] host_data, // Output data word.
  output logic host_valid // Cycle strobe.
);
  initial begin
    ctrl_byte = 8'h00;
    host_data = 16'h0000;
    host_valid = 1'b0;
  end
  // One cycle; the data word is inverted afterwards so stale data shows.
  task xfer(input [7:0] c, input [15:0] d);
    @(posedge clk);
    ctrl_byte <= c;
    host_data <= d;
    host_valid <= 1'b1;
    @(posedge clk);
    host_valid <= 1'b0;
    host_data <= ~d;
  endtask
endmodule

// ### aivp_main_tb.sv
// Self-checking bench for the value processing block.
// Assumes the checker is bound in and the host model drives requests.
`timescale 1ns/1ps
module aivp_main_tb;
  logic clk = 1'b0, rstn = 1'b0, nv_erase = 1'b1, raw_valid = 1'b0;
  logic [15:0] raw_value = 16'h0000;
  wire [7:0] ctrl_byte, status_byte_q;
  wire [15:0] host_data, data_in_q, pd_word_q;
  wire host_valid, ans_valid_q, pd_valid_q, wd_trip_q, load_busy_q;
  logic [15:0] q;
  logic [7:0] s;
  int mismatches = 0, cmp_count = 0;
  logic [5:0] ix [8] = '{6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h1f,
    6'h20};
  logic [15:0] rv [8] = '{16'h0000, 16'h1350, 16'h0000, 16'h2000, 16'h0fff,
    16'h0000, 16'h0000, 16'h0906};
  // Short watchdog count keeps the trip test brief.
  aivp_main #(.LIVE_ZERO(1), .WD_CYCLES(50)) DUT (.clk(clk), .rstn(rstn),
    .nv_erase(nv_erase), .raw_value(raw_value), .raw_valid(raw_valid),
    .host_valid(host_valid), .ctrl_byte(ctrl_byte), .host_data(host_data),
    .status_byte_q(status_byte_q), .data_in_q(data_in_q),
    .ans_valid_q(ans_valid_q), .pd_word_q(pd_word_q),
    .pd_valid_q(pd_valid_q), .wd_trip_q(wd_trip_q),
    .load_busy_q(load_busy_q));
  // Zero-based variant sees the same traffic; only its value is compared.
  wire [15:0] zb_word;
  aivp_main #(.LIVE_ZERO(0), .WD_CYCLES(50)) DUT_ZB (.clk(clk),
    .rstn(rstn), .nv_erase(nv_erase), .raw_value(raw_value),
    .raw_valid(raw_valid), .host_valid(host_valid), .ctrl_byte(ctrl_byte),
    .host_data(host_data), .status_byte_q(), .data_in_q(), .ans_valid_q(),
    .pd_word_q(zb_word), .pd_valid_q(), .wd_trip_q(), .load_busy_q());
  aivp_host_model HM (.clk(clk), .ctrl_byte(ctrl_byte),
    .host_data(host_data), .host_valid(host_valid));
  // Clock of 25 ns period.
  initial begin
    forever #12.5 clk = ~clk;
  end
  // ****************************************
  // Tasks.
  // ****************************************
  task tally_and_finish;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Reset for six cycles, then wait for the restore to finish.
  task rst;
    rstn <= 1'b0;
    repeat (6) @(posedge clk);
    nv_erase <= 1'b0;
    rstn <= 1'b1;
    for (int i = 0; i < 100 && load_busy_q !== 1'b0; i++) @(posedge clk);
    chk({15'h0, load_busy_q}, 16'h0000);
  endtask
  task acc(input [7:0] c, input [15:0] d);
    HM.xfer(c, d);
    #1;
    chk({15'h0, ans_valid_q}, 16'h0001);
    q = data_in_q;
    s = status_byte_q;
  endtask
  task rd(input [5:0] i, input [15:0] e);
    acc({2'b10, i}, 16'h0000);
    chk(q, e);
  endtask
  task wr(input [5:0] i, input [15:0] d);
    acc({2'b11, i}, d);
  endtask
  // Process-mode cycle; compares the status byte.
  task st(input [7:0] e);
    acc(8'h00, 16'h0000);
    chk({8'h00, s}, {8'h00, e});
  endtask
  task smp(input [15:0] r, input [15:0] e);
    @(posedge clk);
    raw_value <= r;
    raw_valid <= 1'b1;
    @(posedge clk);
    raw_valid <= 1'b0;
    raw_value <= ~r;
    #1;
    chk({15'h0, pd_valid_q}, 16'h0001);
    chk(pd_word_q, e);
  endtask
  // ****************************************
  // Main sequence and watchdog.
  // ****************************************
  initial begin
    #125000;
    mismatches++;
    tally_and_finish;
  end
  initial begin
    rst;
    for (int i = 0; i < 8; i++) rd(ix[i], rv[i]);
    wr(6'h20, 16'h0002);
    rd(6'h20, 16'h0906);
    wr(6'h1f, 16'h1235);
    rd(6'h1f, 16'h1235);
    wr(6'h12, 16'h1000);
    wr(6'h20, 16'h0102);
    smp(16'h0100, 16'h0100);
    smp(16'h2000, 16'h0fff);
    st(8'h42);
    smp(16'hff00, 16'h0000);
    st(8'h41);
    wr(6'h11, 16'h0010);
    smp(16'h0100, 16'h0110);
    wr(6'h11, 16'h0000);
    wr(6'h20, 16'h000a);
    smp(16'hffff, 16'h8001);
    wr(6'h20, 16'h0112);
    smp(16'h0100, 16'h0800);
    smp(16'h2000, 16'h0001);
    chk(zb_word, 16'h0001);
    smp(16'hff00, 16'h0003);
    chk(zb_word, 16'h0000);
    wr(6'h20, 16'h0100);
    smp(16'h0010, 16'h0080);
    wr(6'h13, 16'h0005);
    smp(16'h0010, 16'h0085);
    wr(6'h20, 16'h0103);
    smp(16'h0100, 16'h0100);
    wr(6'h22, 16'h0800);
    smp(16'h0100, 16'h0200);
    wr(6'h20, 16'h0702);
    wr(6'h23, 16'h0050);
    smp(16'h0100, 16'h0100);
    st(8'h0c);
    wr(6'h20, 16'h0002);
    wr(6'h12, 16'h2000);
    smp(16'h0100, 16'h0200);
    wr(6'h20, 16'h0802);
    smp(16'h0300, 16'h0300);
    wr(6'h20, 16'h0006);
    repeat (60) @(posedge clk);
    #1;
    chk({15'h0, wd_trip_q}, 16'h0001);
    st(8'h20);
    wr(6'h16, 16'h0005);
    rd(6'h30, 16'h0000);
    @(posedge clk);
    rst;
    rd(6'h1f, 16'h0000);
    rd(6'h16, 16'h0005);
    wr(6'h16, 16'h0007);
    rd(6'h16, 16'h0005);
    tally_and_finish;
  end
endmodule
